// File: tb/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic start,
    output logic [23:0] sa,
    output logic adv
);
    initial begin
        start = 0;
        sa = 24'h0;
        adv = 0;
    end
    // Burst after setup is written; 10 MHz is under every limit
    task automatic burst(input logic [23:0] a, input int n);
        @(negedge clk);
        start = 1;
        sa = a;
        @(negedge clk);
        start = 0;
        sa = ~a; // Released address shows junk
        repeat (n) begin
            adv = 1;
            @(negedge clk);
        end
        adv = 0;
    endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk, sys_rst, bs, ba, rv;
    logic [7:0] nv, rdata;
    logic [23:0] bsa, bao;
    vrc_pkg::reg_cmd_t cmd;
    vrc_pkg::read_setup_t st, st2;
    vrc_pkg::proto_t pr;
    int n_fail = 0, n_checks = 0;
    logic [7:0] tv [4] = '{8'h52, 8'h0C, 8'h17, 8'hE5};
    volatile_read_config u_volatile_read_config (.clk(clk),
        .sys_rst(sys_rst), .cmd(cmd), .nv_config(nv), .burst_start(bs),
        .burst_start_addr(bsa), .burst_advance(ba), .rdata(rdata),
        .rdata_valid(rv), .setup(st), .protocol(pr), .burst_addr_out(bao));
    // Forced-fetch variant shares every input
    volatile_read_config #(.FEATURE_FORCE_FETCH(1'h1))
        u_volatile_read_config_forced (.clk(clk), .sys_rst(sys_rst),
        .cmd(cmd), .nv_config(nv), .burst_start(bs),
        .burst_start_addr(bsa), .burst_advance(ba), .rdata(),
        .rdata_valid(), .setup(st2), .protocol(), .burst_addr_out());
    host_model u_host_model (.clk(clk), .start(bs), .sa(bsa), .adv(ba));
    always #50 clk = ~clk;
    task check(input logic [23:0] s, input logic [23:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    function automatic logic [23:0] mk(input logic [7:0] d);
        case (d[1:0])
            2'h0: return vrc_pkg::MASK_16;
            2'h1: return vrc_pkg::MASK_32;
            2'h2: return vrc_pkg::MASK_64;
            default: return vrc_pkg::MASK_NONE;
        endcase
    endfunction
    task wr(input logic [7:0] d);
        @(negedge clk);
        cmd.wr = 1;
        cmd.wdata = d;
        @(negedge clk);
        cmd.wr = 0;
    endtask
    task rd(input logic [7:0] e);
        @(negedge clk);
        cmd.rd = 1;
        @(negedge clk);
        cmd.rd = 0;
        check(rv, 1'h1);
        check(rdata, e & vrc_pkg::RSVD_MASK);
    endtask
    // Setup seen right after the write lands
    task chs(input logic [7:0] d);
        logic [3:0] k;
        k = d[7:4];
        check(st.dummy_cycles, (k == 4'h0 || k == 4'hF) ?
            vrc_pkg::DUMMY_DEFAULT : k);
        check(st.direct_fetch_mode, !d[3]);
        check(st2.direct_fetch_mode, 1'h1);
        check(st.wrap_en, d[1:0] != 2'h3);
        check(st.wrap_mask, mk(d));
    endtask
    task bt(input logic [7:0] d, input logic [23:0] a, input int n);
        logic [23:0] m;
        m = mk(d);
        wr(d);
        u_host_model.burst(a, n);
        check(bao, (a & ~m) | ((a + 24'(n)) & m));
    endtask
    task final_report;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 0;
        sys_rst = 1;
        cmd = '0;
        nv = 8'hF3;
        repeat (6) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        nv = 8'hFF; // Late change must not reach protocol
        chs(vrc_pkg::VRC_RESET);
        rd(vrc_pkg::VRC_RESET);
        check(pr, vrc_pkg::PROTO_QUAD);
        $display("test reset done");
        foreach (tv[i]) begin
            wr(tv[i]);
            chs(tv[i]);
            rd(tv[i]);
        end
        $display("test regs done");
        bt(8'h02, 24'h00013F, 1);
        bt(8'h00, 24'h00001E, 3);
        bt(8'hF3, 24'h00003F, 2);
        $display("test burst done");
        sys_rst = 1;
        nv = 8'hFB; // Dual strap only, seen at the next release
        repeat (2) @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        check(pr, vrc_pkg::PROTO_DUAL);
        chs(vrc_pkg::VRC_RESET);
        $display("test restart done");
        final_report;
    end
endmodule

// File: tb/vrc_chk.sv
`timescale 1ns/1ns
module vrc_chk #(parameter logic FEATURE_FORCE_FETCH = 1'b0) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire vrc_pkg::reg_cmd_t cmd,
    input wire logic burst_start,
    input wire logic burst_advance,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire vrc_pkg::read_setup_t setup,
    input wire vrc_pkg::proto_t protocol,
    input wire logic [23:0] burst_addr_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rd_answer: assert property (cmd.rd |=> rdata_valid)
        else $error("read not answered");
    a_rsvd_zero: assert property (rdata_valid |-> !rdata[2])
        else $error("reserved bit set");
    a_dummy_set: assert property (cmd.wr && cmd.wdata[7:4] != 4'h0
        && cmd.wdata[7:4] != 4'hF |=> setup.dummy_cycles
        == $past(cmd.wdata[7:4])) else $error("dummy wrong");
    a_dummy_dflt: assert property (cmd.wr && (cmd.wdata[7:4] == 4'h0
        || cmd.wdata[7:4] == 4'hF) |=> setup.dummy_cycles
        == vrc_pkg::DUMMY_DEFAULT) else $error("default dummy wrong");
    a_fetch_mode: assert property (cmd.wr
        |=> setup.direct_fetch_mode
        == (FEATURE_FORCE_FETCH || !$past(cmd.wdata[3])))
        else $error("fetch mode wrong");
    a_wrap_on: assert property (cmd.wr |=> setup.wrap_en
        == ($past(cmd.wdata[1:0]) != 2'h3)) else $error("wrap enable");
    a_wrap_mask: assert property (cmd.wr && cmd.wdata[1:0] == 2'h2
        |=> setup.wrap_mask == vrc_pkg::MASK_64) else $error("mask");
    a_wrap_step: assert property (burst_advance && !burst_start
        |=> burst_addr_out
        == (($past(burst_addr_out) & ~$past(setup.wrap_mask))
        | (($past(burst_addr_out) + 24'h1) & $past(setup.wrap_mask))))
        else $error("burst step wrong");
    a_proto_hold: assert property (!$past(sys_rst, 2) |->
        $stable(protocol)) else $error("protocol changed");
    cover property (cmd.wr ##1 cmd.rd);
    cover property (burst_advance && setup.wrap_en);
    cover property (cmd.wr && cmd.wdata[7:4] == 4'h0);
endmodule
bind volatile_read_config vrc_chk #(.FEATURE_FORCE_FETCH(FEATURE_FORCE_FETCH))
    u_vrc_chk (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
    .burst_start(burst_start), .burst_advance(burst_advance),
    .rdata(rdata), .rdata_valid(rdata_valid), .setup(setup),
    .protocol(protocol), .burst_addr_out(burst_addr_out));

// File: verilog/burst_addr.sv
`timescale 1ns/1ns
module burst_addr (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [23:0] start_addr,
    input wire logic advance,
    input wire vrc_pkg::read_setup_t setup,
    output logic [23:0] addr
);
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic [23:0] inc;

    // Wrap keeps high bits, increments only those inside the mask
    always_comb begin
        inc = addr_q + vrc_pkg::ADDR_ONE;
        addr_d = addr_q;
        if (start) begin
            addr_d = start_addr;
        end else if (advance) begin
            if (setup.wrap_en) begin
                addr_d = (addr_q & ~setup.wrap_mask)
                    | (inc & setup.wrap_mask);
            end else begin
                addr_d = inc;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    assign addr = addr_q;
endmodule

// File: verilog/volatile_read_config.sv
`timescale 1ns/1ns
module volatile_read_config #(
    parameter logic FEATURE_FORCE_FETCH = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire vrc_pkg::reg_cmd_t cmd,
    input wire logic [7:0] nv_config,
    input wire logic burst_start,
    input wire logic [23:0] burst_start_addr,
    input wire logic burst_advance,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output vrc_pkg::read_setup_t setup,
    output vrc_pkg::proto_t protocol,
    output logic [23:0] burst_addr_out
);
    // Stored register image, reserved bit already cleared
    logic [7:0] vrc_q;
    logic [7:0] vrc_d;

    // Readback holding register and its one-cycle strobe
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    // Decoded read-side settings handed to the command logic
    vrc_pkg::read_setup_t setup_q;
    vrc_pkg::read_setup_t setup_d;

    // Line protocol, sampled once per reset from the straps
    vrc_pkg::proto_t proto_q;
    vrc_pkg::proto_t proto_d;
    logic proto_taken_q;
    logic proto_taken_d;

    // Command qualifiers and filtered write data
    logic write_hit;
    logic read_hit;
    logic [7:0] wdata_clean;

    // Fields of the value the register holds after this edge
    logic [3:0] dummy_f;
    logic fetch_off_f;
    logic [1:0] wrap_f;
    logic dummy_is_default;

    // Active-low strap bits of the nonvolatile image
    logic quad_strap_n;
    logic dual_strap_n;

    // Command strobes split out of the carrier
    assign write_hit = cmd.wr;
    assign read_hit = cmd.rd;

    // Per-bit write filter; the reserved position is tied low so
    // nothing the host sends can ever be stored there
    for (genvar i = 0; i < $bits(vrc_d); i++) begin : g_wbit
        if (i == vrc_pkg::RSVD_BIT) begin : g_rsvd
            assign wdata_clean[i] = 1'h0;
        end else begin : g_keep
            assign wdata_clean[i] = cmd.wdata[i];
        end
    end

    // Register image: only the dedicated write command changes it,
    // there is no side door from any other command
    always_comb begin
        vrc_d = vrc_q;
        if (write_hit) begin
            vrc_d = wdata_clean;
        end
    end

    // Image register, back to its default on every reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vrc_q <= vrc_pkg::VRC_RESET;
        end else begin
            vrc_q <= vrc_d;
        end
    end

    // Readback answers from the old image when read and write
    // collide; the host sees the new value on its next read
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = read_hit;
        if (read_hit) begin
            rdata_d = vrc_q & vrc_pkg::RSVD_MASK;
        end
    end

    // Data held until the next read so a slow host can still take it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
            rvalid_q <= 1'h0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Fields taken from the next image, so the settings follow the
    // write on the very edge that stores it
    assign dummy_f = vrc_d[vrc_pkg::DUMMY_HI:vrc_pkg::DUMMY_LO];
    assign fetch_off_f = vrc_d[vrc_pkg::FETCH_BIT];
    assign wrap_f = vrc_d[vrc_pkg::WRAP_HI:vrc_pkg::WRAP_LO];

    // Both end codes mean the default count
    assign dummy_is_default = (dummy_f == vrc_pkg::DUMMY_ZERO)
        || (dummy_f == vrc_pkg::DUMMY_ALL);

    // Setting decode from the next image; every output stays registered
    // with no edge of lag between write and effect
    always_comb begin
        setup_d = setup_q;
        if (dummy_is_default) begin
            setup_d.dummy_cycles = vrc_pkg::DUMMY_DEFAULT;
        end else begin
            setup_d.dummy_cycles = dummy_f;
        end
        // Forced-fetch parts ignore the bit altogether
        if (FEATURE_FORCE_FETCH) begin
            setup_d.direct_fetch_mode = 1'h1;
        end else begin
            setup_d.direct_fetch_mode = ~fetch_off_f;
        end
        setup_d.wrap_en = (wrap_f != vrc_pkg::WRAP_SEQ);
        unique case (wrap_f)
            vrc_pkg::WRAP_16: begin
                setup_d.wrap_mask = vrc_pkg::MASK_16;
            end
            vrc_pkg::WRAP_32: begin
                setup_d.wrap_mask = vrc_pkg::MASK_32;
            end
            vrc_pkg::WRAP_64: begin
                setup_d.wrap_mask = vrc_pkg::MASK_64;
            end
            vrc_pkg::WRAP_SEQ: begin
                // Full mask: the wrap step becomes a plain increment
                setup_d.wrap_mask = vrc_pkg::MASK_NONE;
            end
        endcase
    end

    // Settings read as all zero while reset is applied
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setup_q.dummy_cycles <= '0;
            setup_q.direct_fetch_mode <= 1'h0;
            setup_q.wrap_en <= 1'h0;
            setup_q.wrap_mask <= '0;
        end else begin
            setup_q <= setup_d;
        end
    end

    // Straps are low-active: a cleared bit enables that protocol
    assign quad_strap_n = nv_config[vrc_pkg::NV_QUAD_BIT];
    assign dual_strap_n = nv_config[vrc_pkg::NV_DUAL_BIT];

    // Sampled once after reset, standing in for power-on; later
    // strap edits wait for the next reset to be seen
    always_comb begin
        proto_d = proto_q;
        proto_taken_d = 1'h1;
        if (!proto_taken_q) begin
            if (!quad_strap_n) begin
                // Quad wins when both straps are cleared
                proto_d = vrc_pkg::PROTO_QUAD;
            end else if (!dual_strap_n) begin
                proto_d = vrc_pkg::PROTO_DUAL;
            end else begin
                proto_d = vrc_pkg::PROTO_EXT;
            end
        end
    end

    // Protocol and its one-shot sample flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            proto_q <= vrc_pkg::PROTO_EXT;
            proto_taken_q <= 1'h0;
        end else begin
            proto_q <= proto_d;
            proto_taken_q <= proto_taken_d;
        end
    end

    // Burst address follows the registered settings, so a write
    // issued mid-burst changes the wrap from the next step on
    burst_addr u_burst (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(burst_start),
        .start_addr(burst_start_addr),
        .advance(burst_advance),
        .setup(setup_q),
        .addr(burst_addr_out)
    );

    // Every output is a flop seen straight through
    assign rdata = rdata_q;
    assign rdata_valid = rvalid_q;
    assign setup = setup_q;
    assign protocol = proto_q;
endmodule

// File: verilog/vrc_pkg.sv
// Behaviour
// - Dummy field bits 7:4 sets dummy clocks after every fast read
// - Dummy codes 0000 and 1111 both select the default count
// - Bit 3 low enables direct fetch; high, the default, disables it
// - Feature digit 2 or 4 parts always fetch directly, bit ignored
// - Wrap codes 00, 01, 10 select 16, 32, 64 byte aligned wrap
// - Wrap code 11, the default, reads sequentially without wrap
// - Wrap address rolls from last byte of block back to first
// - New setting applies when write command completes; commands only
// - Nonvolatile bit 2 low dual, bit 3 low quad; after power-on (here sampled after every reset)
package vrc_pkg;
    localparam int DUMMY_HI = 7;
    localparam int DUMMY_LO = 4;
    localparam int FETCH_BIT = 3;
    localparam int RSVD_BIT = 2;
    localparam int WRAP_HI = 1;
    localparam int WRAP_LO = 0;
    localparam int NV_DUAL_BIT = 2;
    localparam int NV_QUAD_BIT = 3;
    localparam logic [7:0] VRC_RESET = 8'hFB;
    localparam logic [7:0] RSVD_MASK = 8'hFB;
    localparam logic [3:0] DUMMY_ZERO = 4'h0;
    localparam logic [3:0] DUMMY_ALL = 4'hF;
    // Dummy count used for both default codes, tuned for top clock rate
    localparam logic [3:0] DUMMY_DEFAULT = 4'hA;
    localparam logic [1:0] WRAP_16 = 2'h0;
    localparam logic [1:0] WRAP_32 = 2'h1;
    localparam logic [1:0] WRAP_64 = 2'h2;
    localparam logic [1:0] WRAP_SEQ = 2'h3;
    localparam logic [23:0] MASK_16 = 24'h00000F;
    localparam logic [23:0] MASK_32 = 24'h00001F;
    localparam logic [23:0] MASK_64 = 24'h00003F;
    localparam logic [23:0] ADDR_ONE = 24'h000001;
    localparam logic [23:0] MASK_NONE = 24'hFFFFFF;

    typedef enum logic [1:0] {
        PROTO_EXT,
        PROTO_DUAL,
        PROTO_QUAD
    } proto_t;

    // Read-side settings that the command logic consumes
    typedef struct packed {
        logic [3:0] dummy_cycles;
        logic direct_fetch_mode;
        logic wrap_en;
        logic [23:0] wrap_mask;
    } read_setup_t;

    // Register access commands from the serial command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_cmd_t;
endpackage
